// *** cpm_pkg.sv ***
// control panel mode logic: shared constants, states and carriers
// assumes one 40 MHz clock and key inputs already debounced and synchronous
package cpm_pkg;
    // ==========================================================
    // timing
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned WINDOW_MS = 2000;
    localparam int unsigned LONG_MS = 2000;
    localparam int unsigned INIT_MS = 5000;
    localparam int unsigned WINDOW_CYC = CLK_HZ / 1000 * WINDOW_MS;
    localparam int unsigned LONG_CYC = CLK_HZ / 1000 * LONG_MS;
    localparam int unsigned INIT_CYC = CLK_HZ / 1000 * INIT_MS;
    // ==========================================================
    // codes and counts
    localparam logic [7:0] CMD_TRIGGER = 8'h5a;
    localparam logic [2:0] BANK_FIRST = 3'h1;
    localparam logic [2:0] BANK_LAST = 3'h7;
    localparam logic [3:0] TEST_GROUP = 4'ha;
    localparam logic [2:0] PRESS_TEST = 3'h1;
    localparam logic [2:0] PRESS_TUNE = 3'h2;
    localparam logic [2:0] PRESS_AIM = 3'h3;
    localparam logic [2:0] PRESS_FOURTH = 3'h4;
    // ==========================================================
    // states, one-hot
    typedef enum logic [7:0] {
        CPM_NORMAL = 8'h01,
        CPM_COUNT = 8'h02,
        CPM_TEST = 8'h04,
        CPM_TUNE = 8'h08,
        CPM_AIM = 8'h10,
        CPM_BANK = 8'h20,
        CPM_INIT = 8'h40,
        CPM_FOURTH = 8'h80
    } cpm_state_e;
    // ==========================================================
    // decoder result carrier
    typedef struct packed {
        logic done;
        logic ok;
        logic [1:0] center;
    } cpm_decode_s;
    // led carrier
    typedef struct packed {
        logic [2:0] leds;
        logic blink;
    } cpm_led_s;
endpackage

// *** cpm_top.sv ***
// control panel mode logic: read triggers, key modes, banks, init standby
// assumes keys are debounced levels and decoder results are one-cycle pulses
module cpm_top #(
    parameter int unsigned WINDOW_CYC = cpm_pkg::WINDOW_CYC,
    parameter int unsigned LONG_CYC = cpm_pkg::LONG_CYC,
    parameter int unsigned INIT_CYC = cpm_pkg::INIT_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // read sources
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic ext_trig_i,
    input wire logic auto_trig_en_i,
    input wire logic target_seen_i,
    // keys and configuration
    input wire logic trig_key_i,
    input wire logic mode_key_i,
    input wire logic mode_key_dis_i,
    // decoder and tuner results
    input wire cpm_pkg::cpm_decode_s decode_i,
    input wire logic tune_ok_i,
    // outputs
    output logic read_start_o,
    output logic aim_light_o,
    output logic tune_run_o,
    output logic store_bank_o,
    output logic factory_reset_o,
    output logic fourth_sel_o,
    output logic [2:0] active_bank_o,
    output cpm_pkg::cpm_led_s led_o
);
    localparam int CW = $clog2(INIT_CYC + 1);

    cpm_pkg::cpm_state_e st_q, st_d;
    logic [CW-1:0] tmr_q, tmr_d;
    logic [2:0] press_q, press_d;
    logic [2:0] bank_q, bank_d, shown_q, shown_d;
    logic [3:0] tries_q, tries_d, hits_q, hits_d;
    logic mode_q, trig_q, ext_q;
    logic read_q, read_d, store_q, store_d, fac_q, fac_d, four_q, four_d;
    cpm_pkg::cpm_led_s led_q, led_d;
    logic mode_k, mode_rise, mode_fall, trig_rise, both, in_sel;

    // ==========================================================
    // key edges; disabled mode key looks released
    assign mode_k = mode_key_i & ~mode_key_dis_i;
    assign mode_rise = mode_k & ~mode_q;
    assign mode_fall = ~mode_k & mode_q;
    assign trig_rise = trig_key_i & ~trig_q;
    assign both = mode_k & trig_key_i;
    assign in_sel = (st_q == cpm_pkg::CPM_BANK) || (st_q == cpm_pkg::CPM_INIT);

    // ==========================================================
    // next state
    always_comb begin
        st_d = st_q;
        tmr_d = tmr_q;
        press_d = press_q;
        bank_d = bank_q;
        shown_d = shown_q;
        tries_d = tries_q;
        hits_d = hits_q;
        store_d = 1'b0;
        fac_d = 1'b0;
        four_d = 1'b0;
        led_d = led_q;
        // timer counts key hold time or window age, saturating
        if (tmr_q != CW'(INIT_CYC)) begin
            tmr_d = tmr_q + 1'b1;
        end
        // read triggers; trigger key only outside selection
        read_d = (rx_valid_i && rx_data_i == cpm_pkg::CMD_TRIGGER)
            || (ext_trig_i && !ext_q)
            || (auto_trig_en_i && target_seen_i)
            || (trig_rise && !in_sel && st_q != cpm_pkg::CPM_COUNT);
        case (st_q)
            cpm_pkg::CPM_NORMAL, cpm_pkg::CPM_TEST, cpm_pkg::CPM_TUNE,
            cpm_pkg::CPM_AIM, cpm_pkg::CPM_FOURTH: begin
                if (mode_rise) begin
                    tmr_d = '0;
                end
                if (both && tmr_q == CW'(INIT_CYC - 1)) begin
                    st_d = cpm_pkg::CPM_INIT;
                    led_d = '{leds: 3'h2, blink: 1'b1};
                end else if (mode_k && !trig_key_i && tmr_q == CW'(LONG_CYC - 1)) begin
                    st_d = cpm_pkg::CPM_BANK;
                    shown_d = bank_q;
                    led_d = '{leds: bank_q, blink: 1'b1};
                end else if (mode_fall && !trig_key_i && tmr_q < CW'(LONG_CYC)) begin
                    st_d = cpm_pkg::CPM_COUNT;
                    press_d = 3'h1;
                    tmr_d = '0;
                end
            end
            cpm_pkg::CPM_COUNT: begin
                if (mode_rise) begin
                    tmr_d = '0;
                    if (press_q != cpm_pkg::PRESS_FOURTH) begin
                        press_d = press_q + 1'b1;
                    end
                end else if (!mode_k && tmr_q >= CW'(WINDOW_CYC - 1)) begin
                    tries_d = '0;
                    hits_d = '0;
                    led_d = '{leds: 3'h0, blink: 1'b0};
                    case (press_q)
                        cpm_pkg::PRESS_TEST: st_d = cpm_pkg::CPM_TEST;
                        cpm_pkg::PRESS_TUNE: st_d = cpm_pkg::CPM_TUNE;
                        cpm_pkg::PRESS_AIM: st_d = cpm_pkg::CPM_AIM;
                        default: begin
                            st_d = cpm_pkg::CPM_FOURTH;
                            four_d = 1'b1;
                        end
                    endcase
                end
            end
            cpm_pkg::CPM_BANK: begin
                if (mode_rise) begin
                    shown_d = (shown_q == cpm_pkg::BANK_LAST) ? cpm_pkg::BANK_FIRST
                        : shown_q + 1'b1;
                    led_d.leds = shown_d;
                end else if (trig_rise) begin
                    bank_d = shown_q;
                    st_d = cpm_pkg::CPM_NORMAL;
                    led_d = '{leds: 3'h0, blink: 1'b0};
                end
            end
            cpm_pkg::CPM_INIT: begin
                // both keys are still held on entry, so wait for fresh presses
                if (trig_rise && !mode_k) begin
                    fac_d = 1'b1;
                    bank_d = cpm_pkg::BANK_FIRST;
                    st_d = cpm_pkg::CPM_NORMAL;
                    led_d = '{leds: 3'h0, blink: 1'b0};
                end else if (mode_rise && !trig_key_i) begin
                    st_d = cpm_pkg::CPM_NORMAL;
                    led_d = '{leds: 3'h0, blink: 1'b0};
                end
            end
            default: st_d = cpm_pkg::CPM_NORMAL;
        endcase
        // result display in test, tune and aim modes
        if (decode_i.done && st_q == cpm_pkg::CPM_TEST) begin
            tries_d = tries_q + 1'b1;
            hits_d = hits_q + {3'h0, decode_i.ok};
            if (tries_d == cpm_pkg::TEST_GROUP) begin
                led_d = '{leds: hits_d[3:1], blink: 1'b0};
                tries_d = '0;
                hits_d = '0;
            end
        end
        if (tune_ok_i && st_q == cpm_pkg::CPM_TUNE) begin
            store_d = 1'b1;
            led_d = '{leds: 3'h7, blink: 1'b0};
        end
        if (decode_i.done && decode_i.ok && st_q == cpm_pkg::CPM_AIM) begin
            led_d = '{leds: {1'b0, decode_i.center}, blink: 1'b0};
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q <= cpm_pkg::CPM_NORMAL;
            tmr_q <= '0;
            press_q <= '0;
            bank_q <= cpm_pkg::BANK_FIRST;
            shown_q <= cpm_pkg::BANK_FIRST;
            tries_q <= '0;
            hits_q <= '0;
            mode_q <= 1'b0;
            trig_q <= 1'b0;
            ext_q <= 1'b0;
            read_q <= 1'b0;
            store_q <= 1'b0;
            fac_q <= 1'b0;
            four_q <= 1'b0;
            led_q <= '0;
            aim_light_o <= 1'b0;
            tune_run_o <= 1'b0;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            press_q <= press_d;
            bank_q <= bank_d;
            shown_q <= shown_d;
            tries_q <= tries_d;
            hits_q <= hits_d;
            mode_q <= mode_k;
            trig_q <= trig_key_i;
            ext_q <= ext_trig_i;
            read_q <= read_d;
            store_q <= store_d;
            fac_q <= fac_d;
            four_q <= four_d;
            led_q <= led_d;
            aim_light_o <= (st_d == cpm_pkg::CPM_AIM);
            tune_run_o <= (st_d == cpm_pkg::CPM_TUNE);
        end
    end

    assign read_start_o = read_q;
    assign store_bank_o = store_q;
    assign factory_reset_o = fac_q;
    assign fourth_sel_o = four_q;
    assign active_bank_o = bank_q;
    assign led_o = led_q;

    // ==========================================================
    // checks
    chk_cmd_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
        rx_valid_i && rx_data_i == cpm_pkg::CMD_TRIGGER |=> read_start_o)
        else $error("command char did not start read");
    chk_ext_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(ext_trig_i) |=> read_start_o)
        else $error("external trigger did not start read");
    chk_auto_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
        auto_trig_en_i && target_seen_i |=> read_start_o)
        else $error("auto trigger did not start read");
    chk_key_confirm: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (in_sel || st_q == cpm_pkg::CPM_COUNT) && trig_rise && !rx_valid_i && !ext_trig_i
        && !(auto_trig_en_i && target_seen_i) |=> !read_start_o)
        else $error("trigger key read while selecting");
    chk_bank_range: assert property (@(posedge clk_i) disable iff (!nrst_i)
        active_bank_o >= cpm_pkg::BANK_FIRST)
        else $error("active bank out of range");
    chk_bank_step: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_q == cpm_pkg::CPM_BANK && mode_rise && shown_q == cpm_pkg::BANK_LAST
        |=> shown_q == cpm_pkg::BANK_FIRST)
        else $error("bank step did not wrap");
    chk_bank_take: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_q == cpm_pkg::CPM_BANK && trig_rise && !mode_rise
        |=> active_bank_o == $past(shown_q) && st_q == cpm_pkg::CPM_NORMAL)
        else $error("bank not taken");
    chk_init_fac: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_q == cpm_pkg::CPM_INIT && trig_rise && !mode_k
        |=> factory_reset_o && active_bank_o == cpm_pkg::BANK_FIRST)
        else $error("factory restore missing");
    chk_mode_dis: assert property (@(posedge clk_i) disable iff (!nrst_i)
        mode_key_dis_i && st_q == cpm_pkg::CPM_NORMAL && !trig_key_i
        |=> st_q == cpm_pkg::CPM_NORMAL)
        else $error("disabled mode key acted");
    chk_tune_store: assert property (@(posedge clk_i) disable iff (!nrst_i)
        tune_ok_i && st_q == cpm_pkg::CPM_TUNE |=> store_bank_o)
        else $error("tuning did not store");
    chk_aim_light: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_q == cpm_pkg::CPM_AIM |-> aim_light_o)
        else $error("aim light off in aim mode");
    chk_commit_wait: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_q == cpm_pkg::CPM_COUNT && mode_rise |=> st_q == cpm_pkg::CPM_COUNT)
        else $error("commit before window end");
    chk_press_one: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_q == cpm_pkg::CPM_COUNT && press_q == cpm_pkg::PRESS_TEST && !mode_k
        && !mode_q && tmr_q >= CW'(WINDOW_CYC - 1) |=> st_q == cpm_pkg::CPM_TEST)
        else $error("one press did not select test");
    chk_long_bank: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_q == cpm_pkg::CPM_NORMAL && mode_k && mode_q && !trig_key_i
        && tmr_q == CW'(LONG_CYC - 1) |=> st_q == cpm_pkg::CPM_BANK)
        else $error("long press missed bank select");
    chk_both_init: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_q == cpm_pkg::CPM_NORMAL && both && mode_q && tmr_q == CW'(INIT_CYC - 1)
        |=> st_q == cpm_pkg::CPM_INIT)
        else $error("both keys missed init standby");
    chk_test_group: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_q == cpm_pkg::CPM_TEST |-> tries_q < cpm_pkg::TEST_GROUP)
        else $error("test group overran");
    cov_bank: cover property (@(posedge clk_i) disable iff (!nrst_i)
        st_q == cpm_pkg::CPM_BANK && trig_rise);
    cov_init: cover property (@(posedge clk_i) disable iff (!nrst_i) factory_reset_o);
    cov_tune: cover property (@(posedge clk_i) disable iff (!nrst_i) store_bank_o);
    cov_aim: cover property (@(posedge clk_i) disable iff (!nrst_i)
        st_q == cpm_pkg::CPM_AIM && decode_i.done);
endmodule

// *** cpm_operator.sv ***
// operator and host model: keys, trigger wire and serial characters
// assumes the block's clock; keys are debounced levels, high = pressed
module cpm_operator (
    // clock
    input wire logic clk_i,
    // keys, wire and serial
    output logic trig_key_o,
    output logic mode_key_o,
    output logic ext_trig_o,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // idle: keys released, wire inactive
    initial begin
        trig_key_o = 1'b0;
        mode_key_o = 1'b0;
        ext_trig_o = 1'b0;
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
    end
    // every change lands 1 ns after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // one character for one cycle; stale data inverted so it cannot pass as valid
    task automatic send_char(input logic [7:0] c);
        tick(1);
        rx_valid_o = 1'b1;
        rx_data_o = c;
        tick(1);
        rx_valid_o = 1'b0;
        rx_data_o = ~c;
    endtask
    // wire held active three cycles, one read expected
    task automatic pulse_ext();
        tick(1);
        ext_trig_o = 1'b1;
        tick(3);
        ext_trig_o = 1'b0;
    endtask
    // short presses, two cycles down and two up
    task automatic press_mode(input int n);
        repeat (n) begin
            tick(1);
            mode_key_o = 1'b1;
            tick(2);
            mode_key_o = 1'b0;
            tick(1);
        end
    endtask
    task automatic press_trig();
        tick(1);
        trig_key_o = 1'b1;
        tick(2);
        trig_key_o = 1'b0;
    endtask
    // long hold of either or both keys
    task automatic hold(input logic m, input logic t, input int n);
        tick(1);
        mode_key_o = m;
        trig_key_o = t;
        tick(n);
        mode_key_o = 1'b0;
        trig_key_o = 1'b0;
    endtask
endmodule

// *** control_panel_mode_fsm_tb.sv ***
// self-checking bench for the control panel mode logic
// assumes short window, long-press and init counts set by parameter
module control_panel_mode_fsm_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W = 20;
    localparam int L = 20;
    localparam int I = 50;
    logic clk_i;
    logic nrst_i;
    logic auto_trig_en_i, target_seen_i, mode_key_dis_i, tune_ok_i;
    cpm_pkg::cpm_decode_s decode_i;
    logic trig_key, mode_key, ext_trig, rx_valid;
    logic [7:0] rx_data;
    logic read_start_o, aim_light_o, tune_run_o, store_bank_o, factory_reset_o, fourth_sel_o;
    logic [2:0] active_bank_o;
    cpm_pkg::cpm_led_s led_o;
    int n_errors = 0, num_checks = 0, n_rs = 0, n_st = 0, n_fr = 0, n_fs = 0;
    // ==========================================================
    // 40 MHz clock and pulse counters
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        n_rs += read_start_o;
        n_st += store_bank_o;
        n_fr += factory_reset_o;
        n_fs += fourth_sel_o;
    end
    cpm_operator i_cpm_operator (.clk_i(clk_i), .trig_key_o(trig_key), .mode_key_o(mode_key),
        .ext_trig_o(ext_trig), .rx_valid_o(rx_valid), .rx_data_o(rx_data));
    cpm_top #(.WINDOW_CYC(W), .LONG_CYC(L), .INIT_CYC(I)) i_cpm_top (.clk_i(clk_i),
        .nrst_i(nrst_i), .rx_valid_i(rx_valid), .rx_data_i(rx_data), .ext_trig_i(ext_trig),
        .auto_trig_en_i(auto_trig_en_i), .target_seen_i(target_seen_i), .trig_key_i(trig_key),
        .mode_key_i(mode_key), .mode_key_dis_i(mode_key_dis_i), .decode_i(decode_i),
        .tune_ok_i(tune_ok_i), .read_start_o(read_start_o), .aim_light_o(aim_light_o),
        .tune_run_o(tune_run_o), .store_bank_o(store_bank_o), .factory_reset_o(factory_reset_o),
        .fourth_sel_o(fourth_sel_o), .active_bank_o(active_bank_o), .led_o(led_o));
    // ==========================================================
    // helpers
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // one decode attempt, single-cycle done
    task automatic dec(input logic ok, input logic [1:0] c);
        tick(1);
        decode_i = '{done: 1'b1, ok: ok, center: c};
        tick(1);
        decode_i = '0;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        chk({5'h00, active_bank_o}, 8'h01);
        chk({2'h0, read_start_o, aim_light_o, tune_run_o, store_bank_o, factory_reset_o,
            fourth_sel_o}, 8'h00);
        $display("test reset done");
    endtask
    // all four read sources, wrong character and disabled auto refused
    task automatic t_triggers();
        i_cpm_operator.send_char(cpm_pkg::CMD_TRIGGER);
        chk({7'h0, read_start_o}, 8'h01);
        i_cpm_operator.send_char(8'h5b);
        tick(3);
        chk(8'(n_rs), 8'h01);
        i_cpm_operator.pulse_ext();
        tick(3);
        chk(8'(n_rs), 8'h02);
        target_seen_i = 1'b1;
        tick(4);
        auto_trig_en_i = 1'b1;
        tick(4);
        target_seen_i = 1'b0;
        auto_trig_en_i = 1'b0;
        tick(3);
        chk(8'(n_rs), 8'h06);
        i_cpm_operator.press_trig();
        tick(3);
        chk(8'(n_rs), 8'h07);
        $display("test triggers done");
    endtask
    // window restart, each press count, test, tune and aim behaviour
    task automatic t_modes();
        int base;
        i_cpm_operator.press_mode(1);
        tick(W - 8);
        i_cpm_operator.press_mode(1);
        base = n_rs;
        i_cpm_operator.press_trig();
        tick(W - 12);
        chk({6'h0, tune_run_o, 8'(n_rs - base) != 0}, 8'h00);
        tick(15);
        chk({7'h0, tune_run_o}, 8'h01);
        tune_ok_i = 1'b1;
        tick(1);
        tune_ok_i = 1'b0;
        tick(2);
        chk({4'h0, 8'(n_st) == 8'h01, led_o.leds}, 8'h0f);
        i_cpm_operator.press_mode(1);
        tick(W + 5);
        chk({7'h0, tune_run_o}, 8'h00);
        for (int k = 0; k < 10; k++) dec(k < 7, 2'h0);
        tick(2);
        chk({5'h0, led_o.leds}, 8'h03);
        for (int k = 0; k < 9; k++) dec(1'b1, 2'h0);
        tick(2);
        chk({5'h0, led_o.leds}, 8'h03);
        dec(1'b1, 2'h0);
        tick(2);
        chk({5'h0, led_o.leds}, 8'h05);
        i_cpm_operator.press_mode(3);
        tick(W + 5);
        dec(1'b1, 2'h2);
        tick(2);
        chk({4'h0, aim_light_o, led_o.leds}, 8'h0a);
        i_cpm_operator.press_mode(4);
        tick(W + 5);
        chk({6'h0, aim_light_o, 8'(n_fs) == 8'h01}, 8'h01);
        $display("test modes done");
    endtask
    // long press shows bank, presses step it, trigger makes it active
    task automatic t_bank();
        int base;
        i_cpm_operator.hold(1'b1, 1'b0, L + 3);
        tick(2);
        chk({4'h0, led_o}, 8'h03);
        i_cpm_operator.press_mode(2);
        tick(2);
        chk({5'h0, led_o.leds}, 8'h03);
        base = n_rs;
        i_cpm_operator.press_trig();
        tick(3);
        chk({4'h0, active_bank_o, 8'(n_rs - base) != 0}, 8'h06);
        $display("test bank done");
    endtask
    // both keys held: trigger restores, mode key cancels
    task automatic t_init();
        i_cpm_operator.hold(1'b1, 1'b1, I + 3);
        tick(2);
        i_cpm_operator.press_trig();
        tick(3);
        chk({4'h0, active_bank_o, 8'(n_fr) == 8'h01}, 8'h03);
        i_cpm_operator.hold(1'b1, 1'b1, I + 3);
        tick(2);
        i_cpm_operator.press_mode(1);
        tick(W + 5);
        i_cpm_operator.press_trig();
        tick(3);
        chk(8'(n_fr), 8'h01);
        $display("test init done");
    endtask
    // disabled mode key: neither presses nor holds take effect
    task automatic t_disable();
        mode_key_dis_i = 1'b1;
        i_cpm_operator.press_mode(2);
        tick(W + 5);
        i_cpm_operator.hold(1'b1, 1'b0, L + 3);
        tick(2);
        chk({6'h0, tune_run_o, led_o.blink}, 8'h00);
        mode_key_dis_i = 1'b0;
        $display("test disable done");
    endtask
    // ==========================================================
    // main sequence and hang guard
    initial begin
        // every input starts idle; reset held low through the first eight edges
        clk_i = 1'b0;
        nrst_i = 1'b0;
        auto_trig_en_i = 1'b0;
        target_seen_i = 1'b0;
        mode_key_dis_i = 1'b0;
        tune_ok_i = 1'b0;
        decode_i = '0;
        tick(8);
        nrst_i = 1'b1;
        t_reset();
        t_triggers();
        t_modes();
        t_bank();
        t_init();
        t_disable();
        final_report();
    end
    initial begin
        #500000;
        n_errors++;
        final_report();
    end
endmodule
